/* File: rtl/uimsk_top.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - rx threshold code picks fill fraction, resets half
// - tx threshold code picks drain fraction, resets half
// - mask bits fixed per source, upper bits reserved
// - mask written directly, read back as held
// - every mask bit resets to zero
// - raw status read-only, independent of the mask
// - non-modem raw bits reset to zero; level bits then set once fills meet the reset half marks
// - modem raw bits follow line changes after reset
// - masked status is raw gated by mask
// - clear register drops pending sources written one
module uimsk_top #(
  parameter int unsigned FIFO_DEPTH = 32,
  parameter int unsigned FILL_W = $clog2(FIFO_DEPTH + 1)
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [uimsk_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  input wire logic overrun_evt_i,
  input wire logic break_evt_i,
  input wire logic parity_evt_i,
  input wire logic framing_evt_i,
  input wire logic rx_timeout_evt_i,
  input wire logic [FILL_W-1:0] rx_fill_i,
  input wire logic [FILL_W-1:0] tx_fill_i,
  input wire logic dataset_ready_line_n_i,
  input wire logic carrier_detect_line_n_i,
  input wire logic clear_to_send_line_n_i,
  input wire logic ring_indicator_line_n_i,
  output logic overrun_irq_o,
  output logic break_irq_o,
  output logic parity_irq_o,
  output logic framing_irq_o,
  output logic rx_timeout_irq_o,
  output logic tx_level_irq_o,
  output logic rx_level_irq_o,
  output logic dataset_ready_irq_o,
  output logic carrier_detect_irq_o,
  output logic clear_to_send_irq_o,
  output logic ring_indicator_irq_o,
  output logic uart_intr_o
);
  import uimsk_pkg::*;

  // ****************************************************************
  // state of the register file
  // ****************************************************************
  typedef struct packed {
    logic [THR_W-1:0] receive_threshold_select;
    logic [THR_W-1:0] transmit_threshold_select;
    uimsk_src_type mask;
    uimsk_src_type raw;
    logic [MODEM_N-1:0] modem_meta;
    logic [MODEM_N-1:0] modem_sync;
    logic [MODEM_N-1:0] modem_prev;
  } uimsk_state_type;

  uimsk_state_type s_q;
  uimsk_state_type s_d;

  uimsk_reg_if bus_if ();

  logic rx_level_hit;
  logic tx_level_hit;
  logic [MODEM_N-1:0] modem_lines_n;
  logic [MODEM_N-1:0] modem_change;
  uimsk_src_type set_vec;
  uimsk_src_type clr_vec;
  uimsk_src_type masked;
  logic wr_thresh;
  logic wr_mask;
  logic wr_clear;

  // ****************************************************************
  // apb slave
  // ****************************************************************
  uimsk_apb_slave u_apb (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .pready_o(pready_o),
    .prdata_o(prdata_o),
    .pslverr_o(pslverr_o),
    .regs(bus_if.slave)
  );

  // ****************************************************************
  // fifo level comparators
  // ****************************************************************
  // receive side fires once the fifo has filled up to the mark
  uimsk_level_cmp #(
    .DEPTH(FIFO_DEPTH),
    .FILL_W(FILL_W),
    .AT_LEAST(1'b1)
  ) u_rx_cmp (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .code_i(s_q.receive_threshold_select),
    .fill_i(rx_fill_i),
    .hit_o(rx_level_hit)
  );

  // transmit side fires once the fifo has drained down to the mark
  uimsk_level_cmp #(
    .DEPTH(FIFO_DEPTH),
    .FILL_W(FILL_W),
    .AT_LEAST(1'b0)
  ) u_tx_cmp (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .code_i(s_q.transmit_threshold_select),
    .fill_i(tx_fill_i),
    .hit_o(tx_level_hit)
  );

  // ****************************************************************
  // modem line change detection
  // ****************************************************************
  // pins are asynchronous; bit order follows the status layout
  assign modem_lines_n = {dataset_ready_line_n_i,
                          carrier_detect_line_n_i,
                          clear_to_send_line_n_i,
                          ring_indicator_line_n_i};

  // edges seen only after two flops; a line held low through reset
  // reports one change after release, which software may see
  assign modem_change = s_q.modem_sync ^ s_q.modem_prev;

  // ****************************************************************
  // event collection
  // ****************************************************************
  // each source sits at its fixed position in every status word
  always_comb begin
    set_vec = '0;
    set_vec[POS_OVERRUN] = overrun_evt_i;
    set_vec[POS_BREAK] = break_evt_i;
    set_vec[POS_PARITY] = parity_evt_i;
    set_vec[POS_FRAMING] = framing_evt_i;
    set_vec[POS_RX_TIMEOUT] = rx_timeout_evt_i;
    set_vec[POS_TX_LEVEL] = tx_level_hit;
    set_vec[POS_RX_LEVEL] = rx_level_hit;
    set_vec[POS_DATASET_READY] = modem_change[POS_DATASET_READY];
    set_vec[POS_CARRIER_DETECT] = modem_change[POS_CARRIER_DETECT];
    set_vec[POS_CLEAR_TO_SEND] = modem_change[POS_CLEAR_TO_SEND];
    set_vec[POS_RING_INDICATOR] = modem_change[POS_RING_INDICATOR];
  end

  // ****************************************************************
  // write decode
  // ****************************************************************
  // raw and masked words are read-only, so writes there do nothing
  assign wr_thresh = bus_if.wr_en && (bus_if.addr == OFS_THRESH);
  assign wr_mask = bus_if.wr_en && (bus_if.addr == OFS_MASK);
  assign wr_clear = bus_if.wr_en && (bus_if.addr == OFS_CLEAR);

  // only bits written as one clear; zeros leave sources alone
  assign clr_vec = wr_clear ? bus_if.wdata[SRC_N-1:0] : '0;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    // two flop synchroniser, then a history flop for edges
    s_d.modem_meta = modem_lines_n;
    s_d.modem_sync = s_q.modem_meta;
    s_d.modem_prev = s_q.modem_sync;
    if (wr_thresh) begin
      // reserved codes are stored as written; they just never fire
      s_d.receive_threshold_select = bus_if.wdata[RX_THR_LSB +: THR_W];
      s_d.transmit_threshold_select = bus_if.wdata[TX_THR_LSB +: THR_W];
    end
    if (wr_mask) begin
      s_d.mask = bus_if.wdata[SRC_N-1:0];
    end
    // a new event in the clearing cycle survives the clear
    s_d.raw = (s_q.raw & ~clr_vec) | set_vec;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q.receive_threshold_select <= RST_RX_THR;
      s_q.transmit_threshold_select <= RST_TX_THR;
      s_q.mask <= RST_MASK;
      s_q.raw <= RST_RAW;
      s_q.modem_meta <= RST_MODEM_LINES;
      s_q.modem_sync <= RST_MODEM_LINES;
      s_q.modem_prev <= RST_MODEM_LINES;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  // reserved bits and the clear register read back as zero
  always_comb begin
    bus_if.rdata = 32'h00000000;
    bus_if.hit = 1'b1;
    case (bus_if.addr)
      OFS_THRESH: begin
        bus_if.rdata[RX_THR_LSB +: THR_W] = s_q.receive_threshold_select;
        bus_if.rdata[TX_THR_LSB +: THR_W] = s_q.transmit_threshold_select;
      end
      OFS_MASK: begin
        bus_if.rdata[SRC_N-1:0] = s_q.mask;
      end
      OFS_RAW: begin
        bus_if.rdata[SRC_N-1:0] = s_q.raw;
      end
      OFS_MASKED: begin
        bus_if.rdata[SRC_N-1:0] = masked;
      end
      OFS_CLEAR: begin
        bus_if.rdata = 32'h00000000;
      end
      default: begin
        bus_if.hit = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // interrupt outputs
  // ****************************************************************
  // gating by the mask never alters the raw word itself
  assign masked = s_q.raw & s_q.mask;

  assign overrun_irq_o = masked[POS_OVERRUN];
  assign break_irq_o = masked[POS_BREAK];
  assign parity_irq_o = masked[POS_PARITY];
  assign framing_irq_o = masked[POS_FRAMING];
  assign rx_timeout_irq_o = masked[POS_RX_TIMEOUT];
  assign tx_level_irq_o = masked[POS_TX_LEVEL];
  assign rx_level_irq_o = masked[POS_RX_LEVEL];
  assign dataset_ready_irq_o = masked[POS_DATASET_READY];
  assign carrier_detect_irq_o = masked[POS_CARRIER_DETECT];
  assign clear_to_send_irq_o = masked[POS_CLEAR_TO_SEND];
  assign ring_indicator_irq_o = masked[POS_RING_INDICATOR];

  // one level line for the interrupt controller
  assign uart_intr_o = |masked;

endmodule : uimsk_top
`default_nettype wire

/* File: rtl/uimsk_pkg.sv */
// ****************************************************************
// interrupt mask and status block: shared constants and types
// ****************************************************************
`default_nettype none
package uimsk_pkg;

  // ****************************************************************
  // register map, byte addresses on the apb bus
  // ****************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_THRESH = 12'h034;
  localparam logic [11:0] OFS_MASK = 12'h038;
  localparam logic [11:0] OFS_RAW = 12'h03C;
  localparam logic [11:0] OFS_MASKED = 12'h040;
  localparam logic [11:0] OFS_CLEAR = 12'h044;

  // ****************************************************************
  // source bit positions, shared by mask, raw, masked and clear
  // ****************************************************************
  localparam int unsigned SRC_N = 11;
  localparam int unsigned POS_OVERRUN = 10;
  localparam int unsigned POS_BREAK = 9;
  localparam int unsigned POS_PARITY = 8;
  localparam int unsigned POS_FRAMING = 7;
  localparam int unsigned POS_RX_TIMEOUT = 6;
  localparam int unsigned POS_TX_LEVEL = 5;
  localparam int unsigned POS_RX_LEVEL = 4;
  localparam int unsigned POS_DATASET_READY = 3;
  localparam int unsigned POS_CARRIER_DETECT = 2;
  localparam int unsigned POS_CLEAR_TO_SEND = 1;
  localparam int unsigned POS_RING_INDICATOR = 0;
  localparam int unsigned MODEM_N = 4;

  // ****************************************************************
  // threshold field layout and codes
  // ****************************************************************
  localparam int unsigned THR_W = 3;
  localparam int unsigned RX_THR_LSB = 3;
  localparam int unsigned TX_THR_LSB = 0;
  localparam logic [2:0] CODE_EIGHTH = 3'h0;
  localparam logic [2:0] CODE_QUARTER = 3'h1;
  localparam logic [2:0] CODE_HALF = 3'h2;
  localparam logic [2:0] CODE_THREE_QUARTERS = 3'h3;
  localparam logic [2:0] CODE_SEVEN_EIGHTHS = 3'h4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [2:0] RST_RX_THR = 3'h2;
  localparam logic [2:0] RST_TX_THR = 3'h2;
  localparam logic [10:0] RST_MASK = 11'h000;
  localparam logic [10:0] RST_RAW = 11'h000;
  localparam logic [3:0] RST_MODEM_LINES = 4'hF;

  typedef logic [SRC_N-1:0] uimsk_src_type;

endpackage : uimsk_pkg
`default_nettype wire

/* File: rtl/uimsk_reg_if.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// register access carrier between apb slave and register file
// ****************************************************************
interface uimsk_reg_if;
  import uimsk_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic wr_en;
  logic [31:0] rdata;
  logic hit;
  modport slave (output addr, output wdata, output wr_en, input rdata, input hit);
  modport regs (input addr, input wdata, input wr_en, output rdata, output hit);
endinterface : uimsk_reg_if
`default_nettype wire

/* File: rtl/uimsk_level_cmp.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// fifo fill level against a threshold in eighths of capacity
// ****************************************************************
module uimsk_level_cmp #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned FILL_W = 6,
  parameter bit AT_LEAST = 1'b1
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [2:0] code_i,
  input wire logic [FILL_W-1:0] fill_i,
  output logic hit_o
);
  import uimsk_pkg::*;

  typedef struct packed {
    logic hit;
  } uimsk_cmp_state_type;

  uimsk_cmp_state_type s_q, s_d;
  int unsigned eighths;
  logic [FILL_W-1:0] thr;

  // reserved codes never fire, so a bad setting stays quiet
  always_comb begin
    eighths = 0;
    case (code_i)
      CODE_EIGHTH: eighths = 1;
      CODE_QUARTER: eighths = 2;
      CODE_HALF: eighths = 4;
      CODE_THREE_QUARTERS: eighths = 6;
      CODE_SEVEN_EIGHTHS: eighths = 7;
      default: eighths = 0;
    endcase
    thr = FILL_W'((DEPTH * eighths) / 8);
    s_d = s_q;
    if (eighths == 0) begin
      s_d.hit = 1'b0;
    end else if (AT_LEAST) begin
      s_d.hit = (fill_i >= thr);
    end else begin
      s_d.hit = (fill_i <= thr);
    end
  end

  // registered so the compare path stays out of the status logic
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hit_o = s_q.hit;

endmodule : uimsk_level_cmp
`default_nettype wire

/* File: rtl/uimsk_apb_slave.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// apb slave, zero wait states, read data captured in setup
// ****************************************************************
module uimsk_apb_slave (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [uimsk_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  uimsk_reg_if.slave regs
);
  import uimsk_pkg::*;

  typedef struct packed {
    logic [31:0] rdata;
    logic err;
  } uimsk_apb_state_type;

  uimsk_apb_state_type s_q, s_d;

  // decode runs in the setup cycle; the access cycle only presents it
  always_comb begin
    s_d = s_q;
    if (psel_i && !penable_i) begin
      s_d.rdata = regs.hit ? regs.rdata : 32'h00000000;
      s_d.err = !regs.hit;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // write lands on the access edge; unmapped writes are dropped
  assign regs.addr = paddr_i;
  assign regs.wdata = pwdata_i;
  assign regs.wr_en = psel_i && penable_i && pwrite_i && regs.hit;
  assign pready_o = 1'b1;
  assign prdata_o = s_q.rdata;
  assign pslverr_o = psel_i && penable_i && s_q.err;

endmodule : uimsk_apb_slave
`default_nettype wire

/* File: verification/uimsk_apb_host.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// register-access software: apb master
// ****************************************************************
module uimsk_apb_host (
  input wire logic mclk_i,
  input wire logic pready_i,
  input wire logic [31:0] prdata_i,
  input wire logic pslverr_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o
);
  // bus idle from time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
  end

  // one transfer; request held until pready seen high, one idle cycle after
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge mclk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge mclk_i);
    penable_o <= 1'b1;
    do @(posedge mclk_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask : xfer
endmodule : uimsk_apb_host
`default_nettype wire

/* File: verification/uimsk_chk_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// port-level checker
// ****************************************************************
module uimsk_chk
  import uimsk_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  input wire logic overrun_evt_i,
  input wire logic parity_evt_i,
  input wire logic overrun_irq_o,
  input wire logic break_irq_o,
  input wire logic parity_irq_o,
  input wire logic framing_irq_o,
  input wire logic rx_timeout_irq_o,
  input wire logic tx_level_irq_o,
  input wire logic rx_level_irq_o,
  input wire logic dataset_ready_irq_o,
  input wire logic carrier_detect_irq_o,
  input wire logic clear_to_send_irq_o,
  input wire logic ring_indicator_irq_o,
  input wire logic uart_intr_o
);
  logic wr_acc;
  logic [10:0] irqs;
  // write access edge and gathered outputs
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign irqs = {overrun_irq_o, break_irq_o, parity_irq_o, framing_irq_o, rx_timeout_irq_o,
                 tx_level_irq_o, rx_level_irq_o, dataset_ready_irq_o, carrier_detect_irq_o,
                 clear_to_send_irq_o, ring_indicator_irq_o};
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  property p_or; uart_intr_o == (|irqs); endproperty
  a_or: assert property (p_or) else $error("combined irq wrong");
  property p_rst; $rose(nrst_i) |-> irqs == 11'h000; endproperty
  a_rst: assert property (p_rst) else $error("irq after reset");
  property p_hold; overrun_irq_o && !wr_acc |=> overrun_irq_o; endproperty
  a_hold: assert property (p_hold) else $error("overrun irq dropped");
  property p_clr;
    wr_acc && paddr_i == OFS_CLEAR && pwdata_i[10] && !overrun_evt_i |=> !overrun_irq_o;
  endproperty
  a_clr: assert property (p_clr) else $error("overrun not cleared");
  property p_keep;
    wr_acc && paddr_i == OFS_CLEAR && !pwdata_i[7] && framing_irq_o |=> framing_irq_o;
  endproperty
  a_keep: assert property (p_keep) else $error("framing cleared wrongly");
  property p_moff; wr_acc && paddr_i == OFS_MASK && !pwdata_i[9] |=> !break_irq_o; endproperty
  a_moff: assert property (p_moff) else $error("break irq despite mask");
  property p_rise;
    $rose(parity_irq_o) |-> $past(parity_evt_i) || $past(wr_acc && paddr_i == OFS_MASK);
  endproperty
  a_rise: assert property (p_rise) else $error("parity irq without cause");
  property p_rsv; psel_i && penable_i && !pwrite_i |-> prdata_o[31:11] == 21'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");

  // main scenarios reached
  c_intr: cover property (uart_intr_o);
  c_clr: cover property (wr_acc && paddr_i == OFS_CLEAR);
  c_err: cover property (pslverr_o);
endmodule : uimsk_chk
bind uimsk_top uimsk_chk chk_u (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pslverr_o(pslverr_o), .overrun_evt_i(overrun_evt_i), .parity_evt_i(parity_evt_i),
  .overrun_irq_o(overrun_irq_o), .break_irq_o(break_irq_o), .parity_irq_o(parity_irq_o),
  .framing_irq_o(framing_irq_o), .rx_timeout_irq_o(rx_timeout_irq_o),
  .tx_level_irq_o(tx_level_irq_o), .rx_level_irq_o(rx_level_irq_o),
  .dataset_ready_irq_o(dataset_ready_irq_o), .carrier_detect_irq_o(carrier_detect_irq_o),
  .clear_to_send_irq_o(clear_to_send_irq_o), .ring_indicator_irq_o(ring_indicator_irq_o),
  .uart_intr_o(uart_intr_o)
);
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import uimsk_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [4:0] evt = 5'h00;
  logic [3:0] mdm = 4'hF;
  logic [5:0] rx_fill = 6'h00;
  logic [5:0] tx_fill = 6'h1F;
  logic psel, penable, pwrite, pready, pslverr, intr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, b;
  wire [10:0] irq;
  logic [5:0] t;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;

  uimsk_apb_host host_u (.mclk_i(mclk_i), .pready_i(pready), .prdata_i(prdata),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));

  uimsk_top dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .overrun_evt_i(evt[4]), .break_evt_i(evt[3]),
    .parity_evt_i(evt[2]), .framing_evt_i(evt[1]), .rx_timeout_evt_i(evt[0]),
    .rx_fill_i(rx_fill), .tx_fill_i(tx_fill), .dataset_ready_line_n_i(mdm[3]),
    .carrier_detect_line_n_i(mdm[2]), .clear_to_send_line_n_i(mdm[1]),
    .ring_indicator_line_n_i(mdm[0]), .overrun_irq_o(irq[10]), .break_irq_o(irq[9]),
    .parity_irq_o(irq[8]), .framing_irq_o(irq[7]), .rx_timeout_irq_o(irq[6]),
    .tx_level_irq_o(irq[5]), .rx_level_irq_o(irq[4]), .dataset_ready_irq_o(irq[3]),
    .carrier_detect_irq_o(irq[2]), .clear_to_send_irq_o(irq[1]),
    .ring_indicator_irq_o(irq[0]), .uart_intr_o(intr));

  // ****************************************************************
  // clock, hang guard and helpers
  // ****************************************************************
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  // whole run needs a few hundred cycles; generous ceiling
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task summarize;
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q, er);
    chk("wr_err", {31'h0, er}, 32'h0);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] e);
    host_u.xfer(1'b0, a, 32'h0, q, er);
    chk($sformatf("reg_%h", a), q, e);
  endtask : rd

  task wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wt

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    wt(8);
    nrst_i <= 1'b1;
    rd(OFS_THRESH, 32'h12);
    rd(OFS_MASK, 32'h0);
    rd(OFS_RAW, 32'h0);
    wr(OFS_MASK, 32'hFFFFFFFF);
    rd(OFS_MASK, 32'h7FF);
    wr(OFS_MASK, 32'h0);
    rd(OFS_MASK, 32'h0);
    wr(OFS_RAW, 32'h7FF);
    rd(OFS_RAW, 32'h0);
    host_u.xfer(1'b0, 12'h100, 32'h0, q, er);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    chk("unmapped_data", q, 32'h0);
    // each event source: raw, masked, combined, selective clear
    for (int i = 0; i < 5; i++) begin
      b = 32'h1 << (i + 6);
      @(posedge mclk_i);
      evt[i] <= 1'b1;
      @(posedge mclk_i);
      evt[i] <= 1'b0;
      rd(OFS_RAW, b);
      rd(OFS_MASKED, 32'h0);
      wr(OFS_MASK, b);
      rd(OFS_MASKED, b);
      wt(1);
      chk("irq", {20'h0, intr, irq}, {20'h0, 1'b1, b[10:0]});
      wr(OFS_CLEAR, b ^ 32'h7FF);
      rd(OFS_RAW, b);
      wr(OFS_CLEAR, b);
      rd(OFS_RAW, 32'h0);
      wr(OFS_MASK, 32'h0);
      wt(1);
      chk("irq_off", {20'h0, intr, irq}, 32'h0);
    end
    // fill thresholds, one step short of and exactly at each trigger point
    for (int c = 0; c < 5; c++) begin
      t = (c == 4) ? 6'd28 : ((c == 3) ? 6'd24 : (6'd4 << c));
      wr(OFS_THRESH, (c << 3) | c);
      rx_fill <= t - 6'd1;
      tx_fill <= t + 6'd1;
      wt(3);
      wr(OFS_CLEAR, 32'h30);
      rd(OFS_RAW, 32'h0);
      rx_fill <= t;
      tx_fill <= t;
      wt(3);
      rd(OFS_RAW, 32'h30);
    end
    // level sources reach their own outputs once unmasked
    wr(OFS_MASK, 32'h30);
    wt(1);
    chk("level_irq", {20'h0, intr, irq}, 32'h830);
    rd(OFS_MASKED, 32'h30);
    wr(OFS_MASK, 32'h0);
    rx_fill <= 6'h00;
    tx_fill <= 6'h1F;
    wt(3);
    wr(OFS_CLEAR, 32'h30);
    rd(OFS_RAW, 32'h0);
    // reserved codes are kept but never fire, even at the extremes
    wr(OFS_THRESH, 32'h2D);
    rx_fill <= 6'd32;
    tx_fill <= 6'd0;
    wt(3);
    rd(OFS_RAW, 32'h0);
    rd(OFS_THRESH, 32'h2D);
    // modem line changes, synchroniser needs a few cycles
    for (int i = 0; i < 4; i++) begin
      mdm[i] <= ~mdm[i];
      wt(5);
      rd(OFS_RAW, 32'h1 << i);
      wr(OFS_MASK, 32'h1 << i);
      wt(1);
      chk("modem_irq", {20'h0, intr, irq}, 32'h800 | (32'h1 << i));
      wr(OFS_CLEAR, 32'h1 << i);
    end
    // mid-run reset with a live mask and pending sources
    wr(OFS_MASK, 32'h7FF);
    @(posedge mclk_i);
    evt <= 5'h1F;
    @(posedge mclk_i);
    evt <= 5'h00;
    wt(1);
    chk("irq_pre", {20'h0, intr, irq}, 32'hFC0);
    // lines and fills go idle with reset so nothing fires on release
    nrst_i <= 1'b0;
    mdm <= 4'hF;
    rx_fill <= 6'h00;
    tx_fill <= 6'h1F;
    wt(2);
    chk("irq_rst", {20'h0, intr, irq}, 32'h0);
    nrst_i <= 1'b1;
    rd(OFS_MASK, 32'h0);
    rd(OFS_RAW, 32'h0);
    rd(OFS_THRESH, 32'h12);
    summarize();
  end
endmodule : testbench
`default_nettype wire
